// ### core/pas_pkg.sv
/*
  Shared constants and types of the serial audio port: clock and frame
  rates, reset configuration, codec-control bus timing and the packed
  configuration and command carriers.
  Assumes a 50 MHz system clock driving every module of the port.
*/
package pas_pkg;

  // ==========================================================
  // Clocking
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned FIFO_DEPTH = 4;

  // ==========================================================
  // Bit clock rates and frame rates
  localparam int unsigned BCLK_256_KHZ = 256;
  localparam int unsigned BCLK_512_KHZ = 512;
  localparam int unsigned BCLK_1024_KHZ = 1024;
  localparam int unsigned BCLK_2048_KHZ = 2048;
  localparam int unsigned BCLK_4096_KHZ = 4096;
  localparam int unsigned FS_8_KHZ = 8;
  localparam int unsigned FS_16_KHZ = 16;

  // Half bit-clock periods in system cycles, rounded down
  localparam logic [7:0] HALF_256 = 8'(CLK_HZ / (2 * BCLK_256_KHZ * 1000));
  localparam logic [7:0] HALF_512 = 8'(CLK_HZ / (2 * BCLK_512_KHZ * 1000));
  localparam logic [7:0] HALF_1024 = 8'(CLK_HZ / (2 * BCLK_1024_KHZ * 1000));
  localparam logic [7:0] HALF_2048 = 8'(CLK_HZ / (2 * BCLK_2048_KHZ * 1000));
  localparam logic [7:0] HALF_4096 = 8'(CLK_HZ / (2 * BCLK_4096_KHZ * 1000));

  // Index of the last bit slot in a frame
  localparam logic [7:0] FRAME_256 = 8'(BCLK_256_KHZ / FS_8_KHZ - 1);
  localparam logic [7:0] FRAME_512 = 8'(BCLK_512_KHZ / FS_8_KHZ - 1);
  localparam logic [7:0] FRAME_1024 = 8'(BCLK_1024_KHZ / FS_8_KHZ - 1);
  localparam logic [7:0] FRAME_2048 = 8'(BCLK_2048_KHZ / FS_8_KHZ - 1);
  localparam logic [7:0] FRAME_4096 = 8'(BCLK_4096_KHZ / FS_16_KHZ - 1);

  // Rate select codes
  localparam logic [2:0] RATE_256 = 3'h0;
  localparam logic [2:0] RATE_512 = 3'h1;
  localparam logic [2:0] RATE_1024 = 3'h2;
  localparam logic [2:0] RATE_2048 = 3'h3;
  localparam logic [2:0] RATE_4096 = 3'h4;

  // ==========================================================
  // Reset values
  localparam logic RST_AUX = 1'b0;
  localparam logic RST_SLAVE = 1'b0;
  localparam logic [2:0] RST_RATE = RATE_2048;
  localparam logic [7:0] BITCNT_IDLE = 8'hff;
  localparam logic [7:0] MSB_SLOT = 8'(WORD_BITS - 1);

  // ==========================================================
  // Codec control bus
  localparam int unsigned I2C_KHZ = 100;
  localparam logic [7:0] I2C_QTR = 8'(CLK_HZ / (4 * I2C_KHZ * 1000));
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  localparam logic [1:0] I2C_LAST_BYTE = 2'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic aux;
    logic slave;
    logic [2:0] rate;
  } pas_cfg_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] regAddr;
    logic [7:0] value;
  } pas_i2c_cmd_t;

  typedef enum logic [1:0] {
    I2C_IDLE = 2'b00,
    I2C_START = 2'b01,
    I2C_XFER = 2'b11,
    I2C_STOP = 2'b10
  } pas_i2c_state_t;

endpackage

// ### core/pas_sync.sv
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes every bit is a slow level or a clock far below clk.
*/
module pas_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // pas_sync

// ### core/pas_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two; full and empty flags are registered.
*/
module pas_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0] count_reg, count_next;
  logic full_reg, full_next, empty_reg, empty_next;
  logic ready_reg, ready_next;
  logic push, pop;

  always_comb begin
    push = inValid && !full_reg && ce;
    pop = outReady && !empty_reg && ce;
    wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
    count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    full_next = count_next == (AW + 1)'(DEPTH);
    empty_next = count_next == '0;
    ready_next = !full_next;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
      ready_reg <= 1'b1;
    end else if (ce) begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      full_reg <= full_next;
      empty_reg <= empty_next;
      ready_reg <= ready_next;
    end
  end

  // Storage is not reset; empty guards every read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Ready comes straight from a flop so the port output needs no gate
  assign inReady = ready_reg;
  assign outValid = !empty_reg;
  assign outData = mem[rdPtr_reg];
endmodule // pas_fifo

// ### core/pas_port.sv
/*
  Serial audio port towards an external codec: bit clock, frame sync,
  data in and out, plus the two-wire control master for the codec.
  Assumes pins are resolved outside from the output enables and that the
  system clock runs well above four times the fastest bit clock.
*/
// Functional notes
// - Primary mode runs as master or slave
// - Auxiliary mode is master only
// - Primary: sample on fall, drive on rise
// - Primary: sync falling edge marks MSB
// - Primary 8 kHz: 256 to 2048 kHz clocks
// - Primary also 4096 kHz clock, 16 kHz sync
// - Auxiliary: sample on fall, drive on rise
// - Auxiliary: sync rising edge marks MSB
// - Auxiliary master: 8 kHz, half-duty sync
// - Samples are 16-bit linear words
// - Reset: primary master, 2048 kHz, 8 kHz
// - Mode, role, rate set by config command
// - Clock, sync driven only as master
// - Device always masters the control bus
module pas_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Configuration command
  input wire logic cfgValid,
  input wire pas_pkg::pas_cfg_t cfgCmd,
  output pas_pkg::pas_cfg_t cfgState,
  // Transmit samples
  input wire logic txValid,
  output logic txReady,
  input wire logic [pas_pkg::WORD_BITS-1:0] txData,
  // Received samples
  output logic rxValid,
  output logic [pas_pkg::WORD_BITS-1:0] rxData,
  // Serial audio pins
  input wire logic pclkIn,
  output logic pclkOut,
  output logic pclkOe,
  input wire logic syncIn,
  output logic syncOut,
  output logic syncOe,
  input wire logic dataIn,
  output logic dataOut,
  // Codec control command
  input wire logic i2cValid,
  input wire pas_pkg::pas_i2c_cmd_t i2cCmd,
  output logic i2cBusy,
  output logic i2cNack,
  // Codec control pins, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);
  localparam int unsigned WB = pas_pkg::WORD_BITS;

  // ==========================================================
  // Pin synchronisers and transmit buffer
  logic [4:0] syn;
  logic pclkS, syncS, dataS, sdaS, sclS;
  logic fifoValid, pop;
  logic [WB-1:0] fifoData;

  pas_sync #(.W(5)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d({sclIn, sdaIn, dataIn, syncIn, pclkIn}),
    .q(syn)
  );
  assign {sclS, sdaS, dataS, syncS, pclkS} = syn;

  // Empty buffer at a frame start sends silence rather than stalling
  pas_fifo #(.WIDTH(WB), .DEPTH(pas_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(pop),
    .outData(fifoData)
  );

  // ==========================================================
  // Audio framing
  pas_pkg::pas_cfg_t cfg_reg, cfg_next, cfgEff;
  logic [7:0] div_reg, div_next, bitCnt_reg, bitCnt_next;
  logic [7:0] halfCyc, frameLast;
  logic [WB-1:0] txShift_reg, txShift_next, rxShift_reg, rxShift_next;
  logic [WB-1:0] rxData_reg, rxData_next;
  logic pclk_reg, pclk_next, pclkPrev_reg, pclkPrev_next;
  logic sync_reg, sync_next, syncAtFall_reg, syncAtFall_next;
  logic dOut_reg, dOut_next, rxValid_reg, rxValid_next;
  logic pclkOe_reg, pclkOe_next, syncOe_reg, syncOe_next;
  logic master, tick, riseEv, fallEv, frameStart;

  always_comb begin
    cfgEff = cfgCmd;
    if (cfgEff.aux) begin
      cfgEff.slave = 1'b0;
      if (cfgEff.rate == pas_pkg::RATE_4096) begin
        cfgEff.rate = pas_pkg::RATE_2048;
      end
    end
    case (cfg_reg.rate)
      pas_pkg::RATE_256: begin
        halfCyc = pas_pkg::HALF_256;
        frameLast = pas_pkg::FRAME_256;
      end
      pas_pkg::RATE_512: begin
        halfCyc = pas_pkg::HALF_512;
        frameLast = pas_pkg::FRAME_512;
      end
      pas_pkg::RATE_1024: begin
        halfCyc = pas_pkg::HALF_1024;
        frameLast = pas_pkg::FRAME_1024;
      end
      pas_pkg::RATE_4096: begin
        halfCyc = pas_pkg::HALF_4096;
        frameLast = pas_pkg::FRAME_4096;
      end
      default: begin
        halfCyc = pas_pkg::HALF_2048;
        frameLast = pas_pkg::FRAME_2048;
      end
    endcase

    master = !cfg_reg.slave;
    tick = div_reg == 8'h00;
    riseEv = master ? (tick && !pclk_reg) : (pclkS && !pclkPrev_reg);
    fallEv = master ? (tick && pclk_reg) : (!pclkS && pclkPrev_reg);
    // Slave frame timing comes only from the sync seen at the last fall
    frameStart = master ? (bitCnt_reg >= frameLast) : syncAtFall_reg;

    cfg_next = cfg_reg;
    div_next = tick ? halfCyc - 8'h01 : div_reg - 8'h01;
    pclk_next = (master && tick) ? !pclk_reg : pclk_reg;
    pclkPrev_next = pclkS;
    bitCnt_next = bitCnt_reg;
    txShift_next = txShift_reg;
    rxShift_next = rxShift_reg;
    rxData_next = rxData_reg;
    sync_next = sync_reg;
    syncAtFall_next = syncAtFall_reg;
    dOut_next = dOut_reg;
    rxValid_next = 1'b0;
    pop = 1'b0;

    if (riseEv) begin
      if (frameStart) begin
        bitCnt_next = 8'h00;
        txShift_next = fifoValid ? fifoData : '0;
        pop = fifoValid;
      end else begin
        if (bitCnt_reg != pas_pkg::BITCNT_IDLE) begin
          bitCnt_next = bitCnt_reg + 8'h01;
        end
        // Zeros shift in, so slots past the word drive low
        txShift_next = {txShift_reg[WB-2:0], 1'b0};
      end
      dOut_next = txShift_next[WB-1];
      if (master && cfg_reg.aux) begin
        sync_next = bitCnt_next <= (frameLast >> 1);
      end else if (master) begin
        sync_next = bitCnt_next == frameLast;
      end
    end

    if (fallEv) begin
      syncAtFall_next = master ? 1'b0 : syncS;
      if (bitCnt_reg < 8'(WB)) begin
        rxShift_next = {rxShift_reg[WB-2:0], dataS};
      end
      if (bitCnt_reg == pas_pkg::MSB_SLOT) begin
        rxValid_next = 1'b1;
        rxData_next = {rxShift_reg[WB-2:0], dataS};
      end
    end

    if (cfgValid) begin
      cfg_next = cfgEff;
      div_next = 8'h00;
      pclk_next = 1'b0;
      sync_next = 1'b0;
      syncAtFall_next = 1'b0;
      bitCnt_next = pas_pkg::BITCNT_IDLE;
    end
    pclkOe_next = !cfg_next.slave;
    syncOe_next = !cfg_next.slave;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= '{pas_pkg::RST_AUX, pas_pkg::RST_SLAVE, pas_pkg::RST_RATE};
      div_reg <= 8'h00;
      bitCnt_reg <= pas_pkg::BITCNT_IDLE;
      txShift_reg <= '0;
      rxShift_reg <= '0;
      rxData_reg <= '0;
      pclk_reg <= 1'b0;
      pclkPrev_reg <= 1'b0;
      sync_reg <= 1'b0;
      syncAtFall_reg <= 1'b0;
      dOut_reg <= 1'b0;
      rxValid_reg <= 1'b0;
      pclkOe_reg <= 1'b1;
      syncOe_reg <= 1'b1;
    end else if (ce) begin
      cfg_reg <= cfg_next;
      div_reg <= div_next;
      bitCnt_reg <= bitCnt_next;
      txShift_reg <= txShift_next;
      rxShift_reg <= rxShift_next;
      rxData_reg <= rxData_next;
      pclk_reg <= pclk_next;
      pclkPrev_reg <= pclkPrev_next;
      sync_reg <= sync_next;
      syncAtFall_reg <= syncAtFall_next;
      dOut_reg <= dOut_next;
      rxValid_reg <= rxValid_next;
      pclkOe_reg <= pclkOe_next;
      syncOe_reg <= syncOe_next;
    end
  end

  // ==========================================================
  // Codec control master
  pas_pkg::pas_i2c_state_t st_reg, st_next;
  pas_pkg::pas_i2c_cmd_t cmd_reg, cmd_next;
  logic [7:0] qDiv_reg, qDiv_next, byte_reg, byte_next;
  logic [3:0] bitIdx_reg, bitIdx_next;
  logic [1:0] phase_reg, phase_next, byteIdx_reg, byteIdx_next;
  logic sclOe_reg, sclOe_next, sdaOe_reg, sdaOe_next;
  logic busy_reg, busy_next, nack_reg, nack_next, odLow_reg, qTick;

  always_comb begin
    st_next = st_reg;
    cmd_next = cmd_reg;
    qTick = qDiv_reg == 8'h00;
    qDiv_next = qTick ? pas_pkg::I2C_QTR - 8'h01 : qDiv_reg - 8'h01;
    byte_next = byte_reg;
    bitIdx_next = bitIdx_reg;
    phase_next = phase_reg;
    byteIdx_next = byteIdx_reg;
    sclOe_next = sclOe_reg;
    sdaOe_next = sdaOe_reg;
    busy_next = busy_reg;
    nack_next = nack_reg;
    case (st_reg)
      pas_pkg::I2C_IDLE: begin
        sclOe_next = 1'b0;
        sdaOe_next = 1'b0;
        qDiv_next = pas_pkg::I2C_QTR - 8'h01;
        if (i2cValid) begin
          cmd_next = i2cCmd;
          byte_next = {i2cCmd.addr, 1'b0};
          st_next = pas_pkg::I2C_START;
          phase_next = 2'h0;
          bitIdx_next = 4'h0;
          byteIdx_next = 2'h0;
          busy_next = 1'b1;
          nack_next = 1'b0;
        end
      end
      pas_pkg::I2C_START: begin
        if (qTick && phase_reg == 2'h0) begin
          sdaOe_next = 1'b1;
          phase_next = 2'h1;
        end else if (qTick) begin
          sclOe_next = 1'b1;
          phase_next = 2'h0;
          st_next = pas_pkg::I2C_XFER;
        end
      end
      pas_pkg::I2C_XFER: begin
        if (qTick) begin
          case (phase_reg)
            2'h0: begin
              // Release data during the acknowledge slot
              sdaOe_next = (bitIdx_reg != pas_pkg::I2C_ACK_BIT) && !byte_reg[7];
              phase_next = 2'h1;
            end
            2'h1: begin
              sclOe_next = 1'b0;
              phase_next = 2'h2;
            end
            2'h2: begin
              // Wait while the codec stretches the clock low
              if (sclS) begin
                if (bitIdx_reg == pas_pkg::I2C_ACK_BIT && sdaS) begin
                  nack_next = 1'b1;
                end
                phase_next = 2'h3;
              end
            end
            default: begin
              sclOe_next = 1'b1;
              phase_next = 2'h0;
              if (bitIdx_reg == pas_pkg::I2C_ACK_BIT) begin
                bitIdx_next = 4'h0;
                if (nack_reg || byteIdx_reg == pas_pkg::I2C_LAST_BYTE) begin
                  st_next = pas_pkg::I2C_STOP;
                end else begin
                  byteIdx_next = byteIdx_reg + 2'h1;
                  byte_next = (byteIdx_reg == 2'h0) ? cmd_reg.regAddr : cmd_reg.value;
                end
              end else begin
                bitIdx_next = bitIdx_reg + 4'h1;
                byte_next = {byte_reg[6:0], 1'b0};
              end
            end
          endcase
        end
      end
      pas_pkg::I2C_STOP: begin
        if (qTick) begin
          case (phase_reg)
            2'h0: begin
              sdaOe_next = 1'b1;
              phase_next = 2'h1;
            end
            2'h1: begin
              sclOe_next = 1'b0;
              phase_next = 2'h2;
            end
            default: begin
              sdaOe_next = 1'b0;
              busy_next = 1'b0;
              st_next = pas_pkg::I2C_IDLE;
            end
          endcase
        end
      end
      default: begin
        st_next = pas_pkg::I2C_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= pas_pkg::I2C_IDLE;
      cmd_reg <= '0;
      qDiv_reg <= 8'h00;
      byte_reg <= 8'h00;
      bitIdx_reg <= 4'h0;
      phase_reg <= 2'h0;
      byteIdx_reg <= 2'h0;
      sclOe_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      odLow_reg <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
      cmd_reg <= cmd_next;
      qDiv_reg <= qDiv_next;
      byte_reg <= byte_next;
      bitIdx_reg <= bitIdx_next;
      phase_reg <= phase_next;
      byteIdx_reg <= byteIdx_next;
      sclOe_reg <= sclOe_next;
      sdaOe_reg <= sdaOe_next;
      busy_reg <= busy_next;
      nack_reg <= nack_next;
      odLow_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  assign cfgState = cfg_reg;
  assign rxValid = rxValid_reg;
  assign rxData = rxData_reg;
  assign pclkOut = pclk_reg;
  assign pclkOe = pclkOe_reg;
  assign syncOut = sync_reg;
  assign syncOe = syncOe_reg;
  assign dataOut = dOut_reg;
  assign i2cBusy = busy_reg;
  assign i2cNack = nack_reg;
  assign sclOut = odLow_reg;
  assign sclOe = sclOe_reg;
  assign sdaOut = odLow_reg;
  assign sdaOe = sdaOe_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_aux_master: assert property (cfg_reg.aux |-> !cfg_reg.slave)
    else $error("auxiliary mode running as slave");
  chk_aux_rate: assert property (cfg_reg.aux |-> cfg_reg.rate != pas_pkg::RATE_4096)
    else $error("auxiliary mode at 4096 kHz");
  chk_pin_dir: assert property (ce && cfgValid |=> pclkOe == !cfg_reg.slave && syncOe == pclkOe)
    else $error("clock or sync enable wrong for role");
  chk_short_msb: assert property (!cfg_reg.aux && !cfg_reg.slave && $fell(sync_reg)
    |-> bitCnt_reg == 8'h00)
    else $error("short sync fall not at MSB slot");
  chk_long_msb: assert property (cfg_reg.aux && $rose(sync_reg) |-> bitCnt_reg == 8'h00)
    else $error("long sync rise not at MSB slot");
  chk_long_duty: assert property (cfg_reg.aux && sync_reg |-> bitCnt_reg <= (frameLast >> 1))
    else $error("long sync high past half frame");
  chk_tx_rise: assert property ($changed(dOut_reg) |-> $past(riseEv))
    else $error("data out changed away from rising edge");
  chk_rx_fall: assert property (rxValid_reg |-> $past(fallEv) && $past(bitCnt_reg) == 8'h0f)
    else $error("word delivered off a falling edge");
  chk_slave_resync: assert property (ce && !cfgValid && cfg_reg.slave && riseEv && syncAtFall_reg
    |=> bitCnt_reg == 8'h00)
    else $error("slave bit count not resynchronised");
  chk_msb_first: assert property (ce && !cfgValid && riseEv && frameStart
    |=> dOut_reg == ($past(fifoValid) && $past(fifoData[WB-1])))
    else $error("frame did not open with MSB");
  chk_bus_idle: assert property (st_reg == pas_pkg::I2C_IDLE ##1 st_reg == pas_pkg::I2C_IDLE
    |-> !sclOe_reg && !sdaOe_reg && !busy_reg)
    else $error("control bus driven while idle");

  cov_aux_frame: cover property (cfg_reg.aux && $rose(sync_reg));
  cov_slave_frame: cover property (cfg_reg.slave && riseEv && syncAtFall_reg);
  cov_rx_word: cover property (rxValid_reg);
  cov_bus_done: cover property ($fell(busy_reg) && !nack_reg);
endmodule // pas_port

// ### tb/pas_codec.sv
/*
  Behavioural codec facing the serial audio port, with a bare
  control-bus responder. Assumes the bench resolves every pin.
*/
module pas_codec #(
  parameter logic [15:0] TX_WORD = 16'ha5c3
) (
  // Resolved pins
  input wire logic pclk,
  input wire logic sync,
  input wire logic dout,
  output logic din,
  input wire logic scl,
  input wire logic sda,
  output logic sdaPull,
  // Bench control and results
  input wire logic aux,
  input wire logic genEn,
  input wire logic ackOn,
  output logic genClk,
  output logic genSync,
  output logic [15:0] rxWord,
  output int frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lastSync = 1'b0;
  logic [15:0] shift = 16'h0;
  int slot = 99;
  int nxt;
  int genSlot = 0;
  int sclFalls = 0;

  initial begin
    din = 1'b0;
    sdaPull = 1'b0;
    genClk = 1'b0;
    genSync = 1'b0;
    rxWord = 16'h0;
    frames = 0;
  end

  // ==========================================================
  // Audio frames
  always @(negedge pclk) begin
    if (aux ? (sync && !lastSync) : (!sync && lastSync)) slot = 0;
    else slot = slot + 1;
    lastSync = sync;
    if (slot < 16) shift = {shift[14:0], dout};
    if (slot == 15) begin
      rxWord = shift;
      frames = frames + 1;
    end
  end

  // Past the word the line toggles, so a stale bit can never pass
  always @(posedge pclk) begin
    // Long frames here are 256 slots, so slot 0 follows slot 255
    nxt = (lastSync && !aux) ? 0 : (slot + 1) % 256;
    din = (nxt < 16) ? TX_WORD[15 - nxt] : ~din;
  end

  // Slave timing: 32 slots, sync high in the last one; still when disabled
  always begin
    #80;
    if (genEn) begin
      genClk = ~genClk;
      if (genClk) genSlot = (genSlot + 1) % 32;
      if (genClk) genSync = (genSlot == 31);
    end
  end

  // ==========================================================
  // Control bus: ack the ninth clock of each byte when told to
  always @(negedge sda) if (scl) sclFalls = 0;
  always @(negedge scl) begin
    sclFalls = (sclFalls == 9) ? 1 : sclFalls + 1;
    sdaPull = ackOn && (sclFalls == 9);
  end
endmodule // pas_codec

// ### tb/pas_port_test.sv
/*
  Self-checking bench for the serial audio port and its codec model.
  Assumes the package and design files are compiled first.
*/
module pas_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] CODEC_WORD = 16'ha5c3;
  localparam logic [7:0] HALF [5] = '{pas_pkg::HALF_256, pas_pkg::HALF_512,
    pas_pkg::HALF_1024, pas_pkg::HALF_2048, pas_pkg::HALF_4096};
  logic clk, rstn, cfgValid, txValid, txReady, rxValid, i2cValid, i2cBusy, i2cNack;
  logic pclkOut, pclkOe, syncOut, syncOe, dataOut, sclOut, sclOe, sdaOut, sdaOe;
  logic din, sdaPull, genClk, genSync, codecAux, genEn, ackOn;
  logic [15:0] txData, rxData, rxWord;
  pas_pkg::pas_cfg_t cfgCmd, cfgState;
  pas_pkg::pas_i2c_cmd_t i2cCmd;
  int frames;
  int err_total = 0;
  int checked = 0;
  wire pclk = pclkOe ? pclkOut : genClk;
  wire sync = syncOe ? syncOut : genSync;
  wire scl = !sclOe;
  wire sda = !sdaOe && !sdaPull;

  pas_port i_pas_port (.clk(clk), .rstn(rstn), .ce(1'b1), .cfgValid(cfgValid),
    .cfgCmd(cfgCmd), .cfgState(cfgState), .txValid(txValid), .txReady(txReady),
    .txData(txData), .rxValid(rxValid), .rxData(rxData), .pclkIn(pclk),
    .pclkOut(pclkOut), .pclkOe(pclkOe), .syncIn(sync), .syncOut(syncOut),
    .syncOe(syncOe), .dataIn(din), .dataOut(dataOut), .i2cValid(i2cValid),
    .i2cCmd(i2cCmd), .i2cBusy(i2cBusy), .i2cNack(i2cNack), .sclIn(scl),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));

  pas_codec #(.TX_WORD(CODEC_WORD)) i_pas_codec (.pclk(pclk), .sync(sync),
    .dout(dataOut), .din(din), .scl(scl), .sda(sda), .sdaPull(sdaPull),
    .aux(codecAux), .genEn(genEn), .ackOn(ackOn), .genClk(genClk),
    .genSync(genSync), .rxWord(rxWord), .frames(frames));

  // ==========================================================
  // Checking and waiting
  task automatic finish_test();
    $display("checked %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stallOut();
    err_total++;
    $display("FAIL %0t wait ran out", $time);
    finish_test();
  endtask

  task automatic waitFrames(input int n);
    int start;
    int k;
    start = frames;
    for (k = 0; k < 20000 * n && frames < start + n; k++) @(posedge clk);
    if (frames < start + n) stallOut();
  endtask

  // ==========================================================
  // Scenarios
  task automatic applyCfg(input pas_pkg::pas_cfg_t c);
    cfgValid <= 1'b1;
    cfgCmd <= c;
    @(posedge clk);
    cfgValid <= 1'b0;
    @(posedge clk);
  endtask

  // Fill the buffer until refused, then expect the words one per frame
  task automatic stream(input logic [15:0] base, input int pre, input int cnt);
    int n = 0;
    int k;
    waitFrames(pre);
    txValid <= 1'b1;
    for (k = 0; k < 8; k++) begin
      txData <= base + 16'(n);
      @(posedge clk);
      if (txReady === 1'b1) n++;
    end
    txValid <= 1'b0;
    cmp(16'(n), 16'h4);
    cmp(16'(txReady), 16'h0);
    for (k = 0; k < cnt; k++) begin
      waitFrames(1);
      cmp(rxWord, k < 4 ? base + 16'(k) : 16'h0);
    end
  endtask

  task automatic rxCheck();
    int k;
    for (k = 0; k < 20000 && rxValid !== 1'b1; k++) @(posedge clk);
    if (rxValid !== 1'b1) stallOut();
    cmp(rxData, CODEC_WORD);
  endtask

  // Every rate code, judged by the low phase of the generated bit clock
  task automatic rates();
    int r;
    int k;
    int t;
    for (r = 0; r < 5; r++) begin
      applyCfg({2'b00, 3'(r)});
      cmp(16'(cfgState), 16'(r));
      for (k = 0; k < 400 && !pclkOut; k++) @(posedge clk);
      for (k = 0; k < 400 && pclkOut; k++) @(posedge clk);
      for (t = 0; t < 400 && !pclkOut; t++) @(posedge clk);
      cmp(16'(t), 16'(HALF[r]));
    end
  endtask

  task automatic ctrl(input logic ack);
    int k;
    ackOn <= ack;
    i2cValid <= 1'b1;
    i2cCmd <= {7'h1a, 8'h05, 8'h3c};
    @(posedge clk);
    i2cValid <= 1'b0;
    @(posedge clk);
    cmp(16'(i2cBusy), 16'h1);
    cmp(16'({sclOut, sdaOut}), 16'h0);
    for (k = 0; k < 40000 && i2cBusy; k++) @(posedge clk);
    if (i2cBusy) stallOut();
    cmp(16'(i2cNack), 16'(!ack));
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {rstn, cfgValid, txValid, i2cValid, codecAux, genEn, ackOn} = '0;
    cfgCmd = '0;
    txData = 16'h0;
    i2cCmd = '0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    cmp(16'(cfgState), 16'({2'b00, pas_pkg::RATE_2048}));
    cmp(16'({pclkOe, syncOe}), 16'h3);
    stream(16'h8001, 1, 5);
    rxCheck();
    rates();
    codecAux <= 1'b1;
    applyCfg({1'b1, 1'b1, pas_pkg::RATE_4096});
    cmp(16'(cfgState), 16'({1'b1, 1'b0, pas_pkg::RATE_2048}));
    stream(16'h4100, 1, 2);
    rxCheck();
    codecAux <= 1'b0;
    genEn <= 1'b1;
    applyCfg({1'b0, 1'b1, pas_pkg::RATE_256});
    cmp(16'({pclkOe, syncOe}), 16'h0);
    stream(16'h2200, 3, 5);
    rxCheck();
    genEn <= 1'b0;
    ctrl(1'b1);
    ctrl(1'b0);
    finish_test();
  end
endmodule // pas_port_test
